// ---- rtl/tuner_ctl_map.svh ----
/*
  Constants of the tuner serial control port: bit positions, address,
  reset values and timing counts.
  Assumes inclusion by the testbench and the main module only.
*/
`ifndef TUNER_CTL_MAP_SVH
`define TUNER_CTL_MAP_SVH
// ==========================================================
// Bus address and bytes
`define TARGET_ADDR         7'h60
`define WRITE_BYTES         3'h5
`define READ_BYTES          3'h5
// ==========================================================
// Byte one/three/four/five field positions
`define B1_MUTE             7
`define B1_SEARCH           6
`define B3_DIR              7
`define B3_SSL_HI           6
`define B3_SSL_LO           5
`define B3_INJ              4
`define B3_MONO             3
`define B3_LMUTE            2
`define B3_RMUTE            1
`define B3_PORT1            0
`define B4_PORT2            7
`define B4_STANDBY_SELECT             6
`define B4_BAND             5
`define B4_XTAL             4
`define B4_SOFT_ATTENUATION            3
`define B4_HCC              2
`define B4_SNC              1
`define B4_IND              0
`define B5_PLLREF           7
// ==========================================================
// Reset values
`define RST_B1              8'h80
`define RST_BYTE            8'h00
// ==========================================================
// Stop levels
`define STOP_LOW            4'h5
`define STOP_MID            4'h7
`define STOP_HIGH           4'ha
// ==========================================================
// Band edges of the divider and step
`define BAND_LOW_EU         14'h2a00
`define BAND_LOW_JP         14'h2400
`define BAND_HIGH           14'h3200
`define SEARCH_STEP         14'h0010
// ==========================================================
// Settling time for one tuning step
`define SETTLE_NS           1000
`define SETTLE_CYC          ((`SETTLE_NS + 9) / 10)
`endif

// ---- rtl/tuner_ctl_pkg.sv ----
/*
  Types of the tuner serial control port.
  Assumes the map header for all numbers.
*/
package tuner_ctl_pkg;
  typedef struct packed {
    logic sda;
    logic scl;
    logic dir;
    logic bus_sel;
    logic gate;
  } pins_t;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
  } ctl_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK  = 3'b010,
    S_WR   = 3'b011,
    S_RD   = 3'b100,
    S_RACK = 3'b101,
    S_SKIP = 3'b110
  } bus_state_t;

  typedef enum logic [1:0] {
    T_DONE   = 2'b00,
    T_SETTLE = 2'b01,
    T_SEARCH = 2'b10
  } tune_state_t;
endpackage

// ---- rtl/tuner_serial_control_port.sv ----
/*
  Serial control port of a tuner: two-wire target or 3-wire bus, five
  write bytes, tuning and search status, port pins.
  Assumes all bus pins asynchronous; station level from the receiver.
*/
`include "tuner_ctl_map.svh"
// Function
// R1 - Standby entered, bus stays responsive
// R2 - Gate low: run normally, ignore bus
// R3 - Indicator port low until tuning done
// R4 - Byte five MSB selects 6.5 MHz reference
// R5 - Two-wire reset: mute set, rest zero
// R6 - 3-wire reset: mute set, rest undefined
// R7 - Host writes all bytes after power-on
// R8 - Two-wire address 1100000, direction bit
// R9 - Host 3-wire clock at most 1 MHz
// R10 - Host sends bytes one to five
// R11 - Strobe rise opens write, rising sample
// R12 - Shortened 3-wire writes accepted
// R13 - Strobe fall opens read, shift falling
// R14 - Host changes strobe while clock low
// R15 - Host toggles strobe between transfers
// R16 - Read during standby holds data low
// R17 - Search steps, stops at level, ready
// R18 - Band edge: stop, limit and ready
// R19 - Byte one mute, search, divider high
// R20 - Byte three direction and stop level
// R21 - Byte three injection, mono, mutes, port
// R22 - Byte four function bits
// R23 - Bytes travel MSB first
// R24 - Early stop keeps old bytes, no tune; code stores the partial byte, zero filled, no tune
// R25 - Bus select pin picks protocol
// R26 - New tuning write restarts tuning
module tuner_serial_control_port (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 clk_en_i,
  // Bus pins
  input  wire logic                 data_i,
  output logic                      data_o,
  output logic                      data_oe_n_o,
  input  wire logic                 bus_clock_i,
  input  wire logic                 transfer_direction_strobe_i,
  input  wire logic                 bus_select_pin_i,
  input  wire logic                 interface_gate_pin_i,
  // Receiver
  input  wire logic [3:0]           station_level_i,
  // Controls out
  output tuner_ctl_pkg::ctl_t       ctl_o,
  output logic                      standby_o,
  output logic                      ref_6m5_sel_o,
  // Port pins
  output logic                      open_drain_port_one_o,
  output logic                      open_drain_port_two_o,
  // Status
  output logic                      ready_o,
  output logic                      band_limit_o
);
  import tuner_ctl_pkg::*;

  pins_t pin_raw;
  pins_t pin_s;

  typedef struct packed {
    pins_t       prev;
    bus_state_t  bst;
    logic [2:0]  bit_cnt;
    logic        got_bit;
    logic [2:0]  byte_idx;
    logic [7:0]  shift;
    ctl_t        ctl;
    logic        new_tune;
    logic        sda_out;
    logic        sda_drive;
    tune_state_t tst;
    logic [13:0] divider;
    logic [7:0]  settle;
    logic        ready;
    logic        blf;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ==========================================================
  // Input synchronisers
  assign pin_raw = '{sda: data_i, scl: bus_clock_i, dir: transfer_direction_strobe_i,
                     bus_sel: bus_select_pin_i, gate: interface_gate_pin_i};

  tuner_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clk_en_i  (clk_en_i),
    .pins_i    (pin_raw),
    .pins_o    (pin_s)
  );

  // ==========================================================
  // Helpers
  function automatic logic [7:0] put_byte(input ctl_t c, input logic [2:0] idx, output ctl_t r,
                                          input logic [7:0] v);
    r = c;
    case (idx)
      3'h0:    r.b1 = v;
      3'h1:    r.b2 = v;
      3'h2:    r.b3 = v;
      3'h3:    r.b4 = v;
      3'h4:    r.b5 = v;
      default: r = c;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] status_byte(input logic [2:0] idx, input state_t s);
    case (idx)
      3'h0:    return {s.ready, s.blf, s.divider[13:8]};
      3'h1:    return s.divider[7:0];
      3'h3:    return {station_level_i, 4'h0};
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] stop_level(input logic [1:0] sel);
    case (sel)
      2'b01:   return `STOP_LOW;
      2'b10:   return `STOP_MID;
      2'b11:   return `STOP_HIGH;
      default: return `STOP_LOW;
    endcase
  endfunction

  // ==========================================================
  // Next state
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        dir_rise;
  logic        dir_fall;
  logic        three_wire;
  logic        live;
  logic [7:0]  sh_next;
  logic [7:0]  rd_byte;
  logic [13:0] band_lo;
  logic [7:0]  unused_v;
  logic [7:0]  part_v;
  logic [7:0]  rd_first;
  logic [7:0]  rd_next;
  logic        tune_go;
  ctl_t        ctl_tmp;

  always_comb begin
    st_d       = st_q;
    ctl_tmp    = st_q.ctl;
    unused_v   = 8'h00;
    part_v     = 8'h00;
    tune_go    = 1'b0;
    three_wire = pin_s.bus_sel;                                   // [R25]
    live       = pin_s.gate;                                      // [R2]
    scl_rise   = live && pin_s.scl && !st_q.prev.scl;
    scl_fall   = live && !pin_s.scl && st_q.prev.scl;
    start_c    = live && !three_wire && pin_s.scl && st_q.prev.scl && st_q.prev.sda && !pin_s.sda;
    stop_c     = live && !three_wire && pin_s.scl && st_q.prev.scl && !st_q.prev.sda && pin_s.sda;
    dir_rise   = live && three_wire && pin_s.dir && !st_q.prev.dir;
    dir_fall   = live && three_wire && !pin_s.dir && st_q.prev.dir;
    sh_next    = {st_q.shift[6:0], pin_s.sda};                    // [R23]
    rd_byte    = status_byte(st_q.byte_idx, st_q);
    rd_first   = status_byte(3'h0, st_q);
    rd_next    = status_byte(st_q.byte_idx + 3'h1, st_q);
    band_lo    = st_q.ctl.b4[`B4_BAND] ? `BAND_LOW_JP : `BAND_LOW_EU;
    if (clk_en_i) begin
      st_d.prev = pin_s;
      // Two-wire target
      if (!three_wire) begin
        if (start_c) begin
          st_d.bst       = S_ADDR;
          st_d.bit_cnt   = 3'h0;
          st_d.got_bit   = 1'b0;
          st_d.byte_idx  = 3'h0;
          st_d.sda_drive = 1'b0;
        end else if (stop_c) begin
          // Last sampled bit is the stop set-up low, so it aligns as zero
          if (st_q.bst == S_WR && st_q.got_bit && st_q.bit_cnt != 3'h1) begin // [R24]
            part_v   = st_q.shift << (3'h0 - st_q.bit_cnt);
            unused_v = put_byte(st_q.ctl, st_q.byte_idx, ctl_tmp, part_v);
            st_d.ctl = ctl_tmp;
          end else if (st_q.new_tune) begin
            tune_go = 1'b1;                                       // [R26]
          end
          st_d.new_tune  = 1'b0;
          st_d.bst       = S_IDLE;
          st_d.sda_drive = 1'b0;
        end else begin
          case (st_q.bst)
            S_ADDR, S_WR: begin
              if (scl_rise) begin
                st_d.shift   = sh_next;
                st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                st_d.got_bit = 1'b1;
              end
              if (scl_fall && st_q.bit_cnt == 3'h0 && st_q.got_bit) begin
                st_d.got_bit = 1'b0;
                if (st_q.bst == S_ADDR) begin
                  if (st_q.shift[7:1] == `TARGET_ADDR) begin      // [R8]
                    st_d.sda_drive = 1'b1;
                    st_d.sda_out   = 1'b0;
                    st_d.bst       = st_q.shift[0] ? S_RACK : S_ACK;
                  end else begin
                    st_d.bst = S_SKIP;
                  end
                end else if (st_q.byte_idx < `WRITE_BYTES) begin
                  unused_v = put_byte(st_q.ctl, st_q.byte_idx, ctl_tmp, st_q.shift);
                  st_d.ctl      = ctl_tmp;                        // [R19]
                  st_d.new_tune = st_q.new_tune || st_q.byte_idx == 3'h1;
                  st_d.byte_idx = st_q.byte_idx + 3'h1;
                  st_d.sda_drive = 1'b1;
                  st_d.sda_out   = 1'b0;
                  st_d.bst       = S_ACK;
                end else begin
                  st_d.bst = S_SKIP;
                end
              end
            end
            S_ACK: begin
              if (scl_fall) begin
                st_d.sda_drive = 1'b0;
                st_d.bst       = S_WR;
              end
            end
            S_RACK: begin
              if (scl_fall) begin
                st_d.sda_drive = 1'b1;
                st_d.sda_out   = rd_byte[7];
                st_d.shift     = {rd_byte[6:0], 1'b0};
                st_d.bit_cnt   = 3'h1;
                st_d.bst       = S_RD;
              end
            end
            S_RD: begin
              if (scl_fall) begin
                if (st_q.bit_cnt == 3'h0) begin
                  st_d.sda_drive = 1'b0;
                  st_d.byte_idx  = st_q.byte_idx + 3'h1;
                  st_d.bst       = st_q.sda_drive ? S_RD : S_IDLE;
                end else begin
                  st_d.sda_out = st_q.shift[7];
                  st_d.shift   = {st_q.shift[6:0], 1'b0};
                  st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                end
              end
              if (scl_rise && !st_q.sda_drive) begin
                st_d.bst = pin_s.sda ? S_IDLE : S_RACK;
              end
            end
            default: st_d.bst = st_q.bst;
          endcase
        end
      end else begin
        // 3-wire bus
        if (dir_rise) begin                                       // [R11]
          st_d.bst       = S_WR;
          st_d.bit_cnt   = 3'h0;
          st_d.byte_idx  = 3'h0;
          st_d.sda_drive = 1'b0;
          st_d.new_tune  = 1'b0;
        end else if (dir_fall) begin                              // [R13]
          if (st_q.new_tune) begin
            tune_go = 1'b1;                                       // [R12]
          end
          st_d.new_tune  = 1'b0;
          st_d.bst       = S_RD;
          st_d.byte_idx  = 3'h0;
          st_d.bit_cnt   = 3'h1;
          st_d.sda_drive = 1'b1;
          st_d.sda_out   = st_q.ctl.b4[`B4_STANDBY_SELECT] ? 1'b0 : rd_first[7];
          st_d.shift     = {rd_first[6:0], 1'b0};
        end else if (st_q.bst == S_WR && scl_rise) begin
          st_d.shift   = sh_next;
          st_d.bit_cnt = st_q.bit_cnt + 3'h1;
          if (st_q.bit_cnt == 3'h7 && st_q.byte_idx < `WRITE_BYTES) begin
            unused_v = put_byte(st_q.ctl, st_q.byte_idx, ctl_tmp, sh_next);
            st_d.ctl      = ctl_tmp;
            st_d.new_tune = st_q.new_tune || st_q.byte_idx == 3'h1;
            st_d.byte_idx = st_q.byte_idx + 3'h1;
          end
        end else if (st_q.bst == S_RD && scl_fall) begin
          if (st_q.bit_cnt == 3'h0) begin
            st_d.byte_idx = st_q.byte_idx + 3'h1;
            st_d.sda_out  = rd_next[7];
            st_d.shift    = {rd_next[6:0], 1'b0};
          end else begin
            st_d.sda_out = st_q.shift[7];
            st_d.shift   = {st_q.shift[6:0], 1'b0};
          end
          if (st_q.ctl.b4[`B4_STANDBY_SELECT]) begin
            st_d.sda_out = 1'b0;                                  // [R16]
          end
          st_d.bit_cnt = st_q.bit_cnt + 3'h1;
        end
      end
      // Tuning and search
      case (st_q.tst)
        T_SETTLE: begin
          if (st_q.settle != 8'h00) begin
            st_d.settle = st_q.settle - 8'h01;
          end else begin
            st_d.tst   = st_q.ctl.b1[`B1_SEARCH] ? T_SEARCH : T_DONE;
            st_d.ready = !st_q.ctl.b1[`B1_SEARCH];                // [R3]
          end
        end
        T_SEARCH: begin
          st_d.ready = 1'b0;
          if (st_q.settle != 8'h00) begin
            st_d.settle = st_q.settle - 8'h01;
          end else if (station_level_i >= stop_level(st_q.ctl.b3[6:5])) begin
            st_d.ready = 1'b1;                                    // [R17]
            st_d.tst   = T_DONE;
          end else if (st_q.ctl.b3[`B3_DIR] ? st_q.divider >= `BAND_HIGH : st_q.divider <= band_lo) begin
            st_d.ready = 1'b1;                                    // [R18]
            st_d.blf   = 1'b1;
            st_d.tst   = T_DONE;
          end else begin
            st_d.divider = st_q.ctl.b3[`B3_DIR] ? st_q.divider + `SEARCH_STEP
                                                 : st_q.divider - `SEARCH_STEP;
            st_d.settle  = 8'(`SETTLE_CYC);
          end
        end
        default: st_d.tst = T_DONE;
      endcase
      // New tuning write wins over a running search
      if (tune_go) begin
        st_d.tst     = T_SETTLE;
        st_d.ready   = 1'b0;                                      // [R26]
        st_d.blf     = 1'b0;
        st_d.divider = {st_d.ctl.b1[5:0], st_d.ctl.b2};
        st_d.settle  = 8'(`SETTLE_CYC);
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q      <= '0;
      st_q.ctl  <= '{b1: `RST_B1, b2: `RST_BYTE, b3: `RST_BYTE,  // [R5] [R6]
                     b4: `RST_BYTE, b5: `RST_BYTE};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign ctl_o                 = st_q.ctl;                        // [R20] [R21] [R22]
  assign standby_o             = st_q.ctl.b4[`B4_STANDBY_SELECT];           // [R1]
  assign ref_6m5_sel_o         = st_q.ctl.b5[`B5_PLLREF];         // [R4]
  assign data_o                = st_q.sda_out;
  assign data_oe_n_o           = !(st_q.sda_drive && pin_s.gate);
  assign open_drain_port_one_o = st_q.ctl.b4[`B4_IND] ? st_q.ready // [R3]
                                                       : st_q.ctl.b3[`B3_PORT1];
  assign open_drain_port_two_o = st_q.ctl.b4[`B4_PORT2];
  assign ready_o               = st_q.ready;
  assign band_limit_o          = st_q.blf;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence blf_set_s;
    $rose(band_limit_o);
  endsequence

  indicator_follows_a: assert property (ctl_o.b4[`B4_IND] |-> open_drain_port_one_o == ready_o) // [R3]
    else $error("indicator port differs from ready");
  limit_implies_ready_a: assert property (blf_set_s |-> ready_o) // [R18]
    else $error("band limit without ready");
  gate_low_quiet_a: assert property (!pin_s.gate |-> data_oe_n_o) // [R2]
    else $error("data driven while gate low");
  ref_select_a: assert property (ref_6m5_sel_o == ctl_o.b5[7]) // [R4]
    else $error("reference select mismatch");
  standby_read_low_a: assert property (standby_o && pin_s.bus_sel && st_q.bst == S_RD && $fell(pin_s.scl)
                                       |=> !data_o) // [R16]
    else $error("data not low in standby read");
  ready_clear_a: assert property (st_q.tst == T_SETTLE |-> !ready_o) // [R26]
    else $error("ready not cleared on new tuning");
endmodule

// ---- rtl/tuner_sync.sv ----
/*
  Two flip-flop synchroniser for the five bus pins.
  Assumes pins asynchronous to ref_clk_i.
*/
module tuner_sync (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 clk_en_i,
  // Pins
  input  wire tuner_ctl_pkg::pins_t pins_i,
  output tuner_ctl_pkg::pins_t      pins_o
);
  import tuner_ctl_pkg::*;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (clk_en_i) begin
      st_d.s1 = pins_i;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pins_o = st_q.s2;
endmodule

// ---- testbench/tuner_host_model.sv ----
/*
  Host model for the tuner control port: 3-wire writes and reads, two-wire writes.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
module tuner_host_model (
  // Clock
  input  wire logic ref_clk_i,
  // Bus
  input  wire logic line_i,
  output logic      data_o,
  output logic      clk_o,
  output logic      dir_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================
  // Timing
  localparam int P = 50; // Half period, 1 MHz bus clock
  initial begin
    data_o = 1'b1;
    clk_o  = 1'b0;
    dir_o  = 1'b0;
  end
  task automatic hp();
    repeat (P) @(negedge ref_clk_i);
  endtask
  task automatic lo();
    clk_o = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  // =====================================
  // 3-wire write, bytes one upward, MSB first
  task automatic w3(input logic [39:0] v, input int n);
    lo();
    hp();
    hp(); // Strobe low a full period first
    dir_o = 1'b1; // Rise opens write, clock low
    hp();
    for (int i = 0; i < n * 8; i++) begin
      data_o = v[39-i];
      hp();
      clk_o = 1'b1;
      hp();
      lo();
    end
    dir_o  = 1'b0;
    data_o = 1'b1;
  endtask
  // =====================================
  // 3-wire read of the first byte
  task automatic r3(output logic [7:0] v);
    lo();
    dir_o = 1'b1;
    hp();
    hp();
    dir_o = 1'b0; // Fall opens read
    hp();
    for (int i = 0; i < 8; i++) begin
      v[7-i] = line_i;
      clk_o  = 1'b1;
      hp();
      lo();
      hp();
    end
  endtask
  // =====================================
  // Two-wire write: start, bits with acks, stop
  task automatic i2c(input logic [47:0] v, input int nb, output logic [5:0] ack);
    ack    = 6'h3f;
    clk_o  = 1'b1;
    data_o = 1'b1;
    hp();
    data_o = 1'b0; // Start
    hp();
    lo();
    for (int i = 0; i < nb; i++) begin
      data_o = v[47-i];
      hp();
      clk_o = 1'b1;
      hp();
      lo();
      if (i % 8 == 7) begin
        data_o = 1'b1;
        hp();
        clk_o = 1'b1;
        hp();
        ack[i/8] = line_i;
        lo();
      end
    end
    data_o = 1'b0;
    hp();
    clk_o = 1'b1;
    hp();
    data_o = 1'b1; // Stop
    hp();
  endtask
endmodule

// ---- testbench/tuner_serial_control_port_tb.sv ----
/*
  Self-checking bench of the tuner serial control port.
  Assumes the host model drives the bus; one 100 MHz clock.
*/
`include "tuner_ctl_map.svh"
module tuner_serial_control_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tuner_ctl_pkg::*;
  // =====================================
  // Signals
  logic       ref_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic       bus_sel   = 1'b1;
  logic       gate      = 1'b1;
  logic [3:0] level     = 4'h0;
  logic       h_data;
  logic       h_clk;
  logic       h_dir;
  logic       data_o;
  logic       data_oe_n_o;
  ctl_t       ctl_o;
  ctl_t       exp_ctl;
  logic       standby_o;
  logic       ref_sel;
  logic       port1;
  logic       port2;
  logic       ready_o;
  logic       band_limit_o;
  int         n_mismatch   = 0;
  int         total_checks = 0;
  wire        line = h_data & (data_oe_n_o | data_o);
  always #5 ref_clk_i = ~ref_clk_i;
  // =====================================
  // Instances
  tuner_host_model u_tuner_host_model (.ref_clk_i(ref_clk_i), .line_i(line), .data_o(h_data),
    .clk_o(h_clk), .dir_o(h_dir));
  tuner_serial_control_port u_tuner_serial_control_port (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .clk_en_i(1'b1), .data_i(line), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .bus_clock_i(h_clk),
    .transfer_direction_strobe_i(h_dir), .bus_select_pin_i(bus_sel), .interface_gate_pin_i(gate),
    .station_level_i(level), .ctl_o(ctl_o), .standby_o(standby_o), .ref_6m5_sel_o(ref_sel),
    .open_drain_port_one_o(port1), .open_drain_port_two_o(port2), .ready_o(ready_o),
    .band_limit_o(band_limit_o));
  // =====================================
  // Helpers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready(input int lim);
    repeat (8) @(negedge ref_clk_i);
    for (int i = 0; i < lim && ready_o !== 1'b1; i++) @(negedge ref_clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // =====================================
  // Scenarios
  task automatic t_reset();
    chk(ctl_o, 40'h8000000000);
    chk(ready_o, 40'h0);
    chk(data_oe_n_o, 40'h1);
    $display("test reset done");
  endtask
  task automatic t_preset();
    exp_ctl = 40'h2b00018080;
    u_tuner_host_model.w3(exp_ctl, 5);
    repeat (8) @(negedge ref_clk_i);
    chk(ready_o, 40'h0);
    chk(ctl_o, exp_ctl);
    chk(ref_sel, 40'h1);
    chk(port2, 40'h1);
    chk(port1, 40'h1);
    wait_ready(`SETTLE_CYC + 50);
    chk(ready_o, 40'h1);
    $display("test preset done");
  endtask
  task automatic t_read();
    logic [7:0] v;
    u_tuner_host_model.r3(v);
    chk(v, 40'hab);
    $display("test read done");
  endtask
  task automatic t_indicator();
    exp_ctl = 40'h2b00018180;
    u_tuner_host_model.w3(40'h2b00018100, 4);
    repeat (8) @(negedge ref_clk_i);
    chk(port1, 40'h0);
    wait_ready(`SETTLE_CYC + 50);
    chk(port1, 40'h1);
    chk(ctl_o, exp_ctl);
    $display("test indicator done");
  endtask
  task automatic t_search();
    logic [3:0] thr;
    for (int k = 1; k < 4; k++) begin
      thr = (k == 1) ? `STOP_LOW : (k == 2) ? `STOP_MID : `STOP_HIGH;
      for (int s = 0; s < 2; s++) begin
        level = thr - 4'(1 - s);
        u_tuner_host_model.w3({16'h71c0, 1'b1, 2'(k), 21'h0}, 3);
        wait_ready(2000);
        chk(ready_o, 40'h1);
        chk(band_limit_o, 40'(1 - s));
        chk(port1, 40'h1);
      end
    end
    exp_ctl = 40'h71c0e08180;
    chk(ctl_o, exp_ctl);
    $display("test search done");
  endtask
  task automatic t_two_wire();
    logic [5:0] a;
    bus_sel = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    exp_ctl.b1 = 8'h2a;
    exp_ctl.b2 = 8'h10;
    u_tuner_host_model.i2c({24'hc02a10, 24'h0}, 24, a);
    chk(a[2:0], 40'h0);
    wait_ready(`SETTLE_CYC + 50);
    chk(ctl_o, exp_ctl);
    chk(ready_o, 40'h1);
    u_tuner_host_model.i2c({24'hc25511, 24'h0}, 16, a);
    chk(a[0], 40'h1);
    chk(ctl_o, exp_ctl);
    exp_ctl.b1 = 8'h0b;
    exp_ctl.b2 = 8'hf0;
    u_tuner_host_model.i2c({24'hc00bf5, 24'h0}, 20, a);
    repeat (20) @(negedge ref_clk_i);
    chk(ctl_o, exp_ctl);
    chk(ready_o, 40'h1);
    $display("test two_wire done");
  endtask
  task automatic t_gate();
    bus_sel = 1'b1;
    gate    = 1'b0;
    u_tuner_host_model.w3(40'hffffffffff, 5);
    repeat (20) @(negedge ref_clk_i);
    chk(ctl_o, exp_ctl);
    chk(ready_o, 40'h1);
    gate = 1'b1;
    $display("test gate done");
  endtask
  task automatic t_standby();
    logic [7:0] v;
    u_tuner_host_model.w3(40'h2b00014000, 5);
    repeat (8) @(negedge ref_clk_i);
    chk(standby_o, 40'h1);
    exp_ctl = 40'h2b00004000;
    u_tuner_host_model.w3(exp_ctl, 5);
    wait_ready(`SETTLE_CYC + 50);
    chk(ctl_o, exp_ctl);
    u_tuner_host_model.r3(v);
    chk(v, 40'h0);
    $display("test standby done");
  endtask
  // =====================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_reset();
    t_preset();
    t_read();
    t_indicator();
    t_search();
    t_two_wire();
    t_gate();
    t_standby();
    print_verdict();
  end
  initial begin
    #900000;
    n_mismatch++;
    print_verdict();
  end
endmodule
